// ### include/scc_defines.svh
// Register offsets, reset values, field positions and timing for the shift-chain bank
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH
// --------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------
`define SCC_A_BR_SEL   16'h001A
`define SCC_A_BR_NOW   16'h001B
`define SCC_A_OUT_CFG  16'h001C
`define SCC_A_OUT_NOW  16'h001D
`define SCC_A_IN_CFG   16'h001E
`define SCC_A_IN_NOW   16'h001F
`define SCC_A_TYPE     16'h0020
`define SCC_A_POLICY   16'h0021
`define SCC_A_VALID    16'h0022
// --------------------------------------------------------------
// Reset values and limits
// --------------------------------------------------------------
`define SCC_BR_RST     8'h01
`define SCC_BR_MAX     8'h03
`define SCC_BR_OFF     2'h0
`define SCC_CNT_RST    8'h00
`define SCC_CNT_MAX    16'h0020
`define SCC_POL_RST    6'h00
`define SCC_VAL_RST    8'h00
`define SCC_ERR_MODE   3'h4
// --------------------------------------------------------------
// Safe-value policy codes and fields
// --------------------------------------------------------------
`define SCC_POL_ZERO   2'h0
`define SCC_POL_ONE    2'h1
`define SCC_POL_HOLD   2'h2
`define SCC_POL_CH_HI  1
`define SCC_POL_CH_LO  0
`define SCC_POL_FB_HI  3
`define SCC_POL_FB_LO  2
`define SCC_POL_LK_HI  5
`define SCC_POL_LK_LO  4
// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define SCC_MS_NS      1000000
`define SCC_CLK_NS     4
`endif

// ### include/scc_pkg.sv
// Types shared by the shift-chain configuration bank
package scc_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } scc_reg_req_t;

  typedef enum logic [2:0] {
    SCC_IDLE = 3'b001,
    SCC_RUN  = 3'b010,
    SCC_ERR  = 3'b100
  } scc_state_t;
endpackage

// ### logic/scc_policy_mux.sv
// Safe-value substitution for one output area
`timescale 1ns/10ps
`include "scc_defines.svh"
module scc_policy_mux #(
  parameter int DATA_W = 256
) (
  input  wire logic              ref_clk,  // Clock
  input  wire logic              rst,      // Sync reset
  input  wire logic [DATA_W-1:0] srcData,  // Routed data
  input  wire logic              srcValid, // Source area valid
  input  wire logic [1:0]        policy,   // Safe-value code
  output logic      [DATA_W-1:0] outData   // Output data
);
  if (DATA_W < 1) begin : g_bad
    $error("scc_policy_mux: DATA_W must be positive");
  end

  for (genvar i = 0; i < DATA_W; i++) begin : g_bit
    always_ff @(posedge ref_clk)
    begin
      if (rst)
        outData[i] <= 1'b0;
      else if (srcValid)
        outData[i] <= srcData[i];
      else
      begin
        case (policy)
          `SCC_POL_ONE:  outData[i] <= 1'b1;
          `SCC_POL_HOLD: outData[i] <= outData[i];
          // Undefined code falls back to the safest choice
          default:       outData[i] <= 1'b0;
        endcase
      end
    end
  end
endmodule // scc_policy_mux

// ### logic/scc_validity_timer.sv
// Millisecond validity watchdog for one input area
`timescale 1ns/10ps
`include "scc_defines.svh"
module scc_validity_timer (
  input  wire logic       ref_clk,   // Clock
  input  wire logic       rst,       // Sync reset
  input  wire logic       msTick,    // 1 ms enable
  input  wire logic       produce,   // New data produced
  input  wire logic [7:0] period,    // Validity in ms, 0 = forever
  output logic            dataValid  // Input data valid
);
  logic [7:0] elapsed_q;
  logic       expire;

  // Tick phase is free running, so the gap may run up to 1 ms short
  assign expire = msTick && (period != 8'h00) && ((elapsed_q + 8'h01) >= period);

  always_ff @(posedge ref_clk)
  begin
    if (rst || produce)
      elapsed_q <= 8'h00;
    else if (msTick && dataValid && elapsed_q != 8'hFF)
      elapsed_q <= elapsed_q + 8'h01;
  end

  // Production wins over a same-cycle expiry
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      dataValid <= 1'b0;
    else if (produce || period == 8'h00)
      dataValid <= 1'b1;
    else if (expire)
      dataValid <= 1'b0;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  expiry_drops_a: assert property (expire && !produce |=> !dataValid)
    else $error("data stayed valid past its period");
  endless_valid_a: assert property (period == 8'h00 |=> dataValid)
    else $error("zero period did not hold data valid");
endmodule // scc_validity_timer

// ### logic/scc_config_regs.sv
// Shift-chain port configuration and status register bank
// Functional notes
// - Bitrate select holds a code; 0 off, 1..3 rising rates, reset 1.
// - Current bitrate reads zero if unset or invalid, else the applied code.
// - Output module count 0..32, reset 0, 8 bits per module.
// - Input module count 0..32, reset 0, 8 bits per module.
// - Detected module count differing from configured count enters error state; checked only in master mode with auto detection off.
// - Automatic detection overrides manual counts; software disables it first.
// - Module counts only take effect while in master mode.
// - Read-only register shows output modules in use, 0..32.
// - Read-only register shows input modules in use, 0..32.
// - Read-only byte returns a fixed module type code.
// - Policy bits 1:0 choose chain output reaction: zeros, ones, hold.
// - Policy bits 3:2 choose the fieldbus-fed output reaction.
// - Policy bits 5:4 choose the serial-data-fed output reaction.
// - Chain input data goes invalid when production misses its period.
// - Outputs fed from invalid input switch to the selected safe values.
// - Validity period zero never expires; 1..255 are milliseconds.
// - Mode status reads code four while the chain is in error.
`timescale 1ns/10ps
`include "scc_defines.svh"
module scc_config_regs #(
  parameter int         DATA_W      = 256,
  parameter int         MS_CYCLES   = `SCC_MS_NS / `SCC_CLK_NS,
  parameter logic [7:0] MODULE_TYPE = 8'h5A  // Arbitrary value
) (
  input  wire logic                 ref_clk,       // 250 MHz clock
  input  wire logic                 rst,           // Sync reset
  input  wire scc_pkg::scc_reg_req_t regReq,       // Register request
  output logic      [15:0]          regRdData,     // Read data
  output logic                      regRdValid,    // Read data valid
  output logic                      regAddrErr,    // Unmapped access
  input  wire logic                 masterMode,    // Port in master mode
  input  wire logic                 autoDetect,    // Auto detection selected
  input  wire logic [2:0]           currentMode,   // Mode code from mode logic
  output logic      [2:0]           modeStatus,    // Reported mode code
  input  wire logic                 scanDone,      // Chain scan finished
  input  wire logic [5:0]           detOutCount,   // Detected output modules
  input  wire logic [5:0]           detInCount,    // Detected input modules
  input  wire logic                 applyPulse,    // Settings applied to port
  output logic                      chainError,    // Chain error state
  output logic      [1:0]           bitrateCode,   // Applied bitrate code
  output logic                      portEnable,    // Port running
  output logic      [5:0]           outModsUsed,   // Output modules in use
  output logic      [5:0]           inModsUsed,    // Input modules in use
  input  wire logic                 chainProduce,  // Chain input produced
  output logic                      chainInValid,  // Chain input valid
  input  wire logic [DATA_W-1:0]    chainOutRaw,   // Data routed from chain
  output logic      [DATA_W-1:0]    chainOutSafe,  // Guarded chain data
  input  wire logic                 fbValid,       // Fieldbus input valid
  input  wire logic [DATA_W-1:0]    fbOutRaw,      // Data routed from fieldbus
  output logic      [DATA_W-1:0]    fbOutSafe,     // Guarded fieldbus data
  input  wire logic                 linkValid,     // Serial data input valid
  input  wire logic [DATA_W-1:0]    linkOutRaw,    // Data from serial link
  output logic      [DATA_W-1:0]    linkOutSafe    // Guarded serial data
);
  if (MS_CYCLES < 2 || DATA_W < 1) begin : g_bad
    $error("scc_config_regs: MS_CYCLES >= 2 and DATA_W >= 1 required");
  end

  localparam int MSW = $clog2(MS_CYCLES);

  logic [7:0]          brSel_q;
  logic [7:0]          outCfg_q;
  logic [7:0]          inCfg_q;
  logic [5:0]          policy_q;
  logic [7:0]          valPeriod_q;
  logic [MSW-1:0]      msCnt_q;
  logic                msTick;
  logic                mismatch;
  logic                wrHit;
  logic [15:0]         rdMux;
  logic                rdMiss;
  scc_pkg::scc_state_t state_q;

  // --------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------
  assign wrHit = regReq.wr;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      brSel_q <= `SCC_BR_RST;
    else if (wrHit && regReq.addr == `SCC_A_BR_SEL)
      brSel_q <= regReq.wdata[7:0];
  end

  // Out-of-range counts are ignored and keep the old value
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      outCfg_q <= `SCC_CNT_RST;
    else if (wrHit && regReq.addr == `SCC_A_OUT_CFG && regReq.wdata <= `SCC_CNT_MAX)
      outCfg_q <= regReq.wdata[7:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      inCfg_q <= `SCC_CNT_RST;
    else if (wrHit && regReq.addr == `SCC_A_IN_CFG && regReq.wdata <= `SCC_CNT_MAX)
      inCfg_q <= regReq.wdata[7:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      policy_q <= `SCC_POL_RST;
    else if (wrHit && regReq.addr == `SCC_A_POLICY)
      policy_q <= regReq.wdata[5:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      valPeriod_q <= `SCC_VAL_RST;
    else if (wrHit && regReq.addr == `SCC_A_VALID)
      valPeriod_q <= regReq.wdata[7:0];
  end

  // --------------------------------------------------------------
  // Applied settings
  // --------------------------------------------------------------
  // Status follows only on apply, so software sees what really runs
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      bitrateCode <= `SCC_BR_OFF;
    else if (applyPulse)
      bitrateCode <= (brSel_q <= `SCC_BR_MAX) ? brSel_q[1:0] : `SCC_BR_OFF;
  end

  assign portEnable = (bitrateCode != `SCC_BR_OFF);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      outModsUsed <= 6'h00;
      inModsUsed  <= 6'h00;
    end
    else if (applyPulse)
    begin
      if (!masterMode)
      begin
        outModsUsed <= 6'h00;
        inModsUsed  <= 6'h00;
      end
      else if (autoDetect)
      begin
        outModsUsed <= detOutCount;
        inModsUsed  <= detInCount;
      end
      else
      begin
        outModsUsed <= outCfg_q[5:0];
        inModsUsed  <= inCfg_q[5:0];
      end
    end
  end

  // --------------------------------------------------------------
  // Chain error state
  // --------------------------------------------------------------
  assign mismatch = !autoDetect &&
                    (detOutCount != outCfg_q[5:0] || detInCount != inCfg_q[5:0]);

  always_ff @(posedge ref_clk)
  begin
    if (rst || !masterMode)
      state_q <= scc_pkg::SCC_IDLE;
    else
    begin
      case (state_q)
        scc_pkg::SCC_IDLE:
          state_q <= scc_pkg::SCC_RUN;
        scc_pkg::SCC_RUN:
          if (scanDone && mismatch)
            state_q <= scc_pkg::SCC_ERR;
        scc_pkg::SCC_ERR:
          if (scanDone && !mismatch)
            state_q <= scc_pkg::SCC_RUN;
        default:
          state_q <= scc_pkg::SCC_IDLE;
      endcase
    end
  end

  assign chainError = (state_q == scc_pkg::SCC_ERR);
  assign modeStatus = chainError ? `SCC_ERR_MODE : currentMode;

  // --------------------------------------------------------------
  // Validity and safe values
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst || msTick)
      msCnt_q <= '0;
    else
      msCnt_q <= msCnt_q + 1'b1;
  end

  assign msTick = (msCnt_q == MSW'(MS_CYCLES - 1));

  scc_validity_timer u_chain_timer (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .msTick    (msTick),
    .produce   (chainProduce),
    .period    (valPeriod_q),
    .dataValid (chainInValid)
  );

  scc_policy_mux #(.DATA_W(DATA_W)) u_chain_mux (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .srcData  (chainOutRaw),
    .srcValid (chainInValid),
    .policy   (policy_q[`SCC_POL_CH_HI:`SCC_POL_CH_LO]),
    .outData  (chainOutSafe)
  );

  scc_policy_mux #(.DATA_W(DATA_W)) u_fb_mux (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .srcData  (fbOutRaw),
    .srcValid (fbValid),
    .policy   (policy_q[`SCC_POL_FB_HI:`SCC_POL_FB_LO]),
    .outData  (fbOutSafe)
  );

  scc_policy_mux #(.DATA_W(DATA_W)) u_link_mux (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .srcData  (linkOutRaw),
    .srcValid (linkValid),
    .policy   (policy_q[`SCC_POL_LK_HI:`SCC_POL_LK_LO]),
    .outData  (linkOutSafe)
  );

  // --------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------
  always_comb
  begin
    rdMux  = 16'h0000;
    rdMiss = 1'b0;
    if (regReq.addr == `SCC_A_BR_SEL)
      rdMux = {8'h00, brSel_q};
    else if (regReq.addr == `SCC_A_BR_NOW)
      rdMux = {14'h0000, bitrateCode};
    else if (regReq.addr == `SCC_A_OUT_CFG)
      rdMux = {8'h00, outCfg_q};
    else if (regReq.addr == `SCC_A_OUT_NOW)
      rdMux = {10'h000, outModsUsed};
    else if (regReq.addr == `SCC_A_IN_CFG)
      rdMux = {8'h00, inCfg_q};
    else if (regReq.addr == `SCC_A_IN_NOW)
      rdMux = {10'h000, inModsUsed};
    else if (regReq.addr == `SCC_A_TYPE)
      rdMux = {8'h00, MODULE_TYPE};
    else if (regReq.addr == `SCC_A_POLICY)
      rdMux = {10'h000, policy_q};
    else if (regReq.addr == `SCC_A_VALID)
      rdMux = {8'h00, valPeriod_q};
    else
      rdMiss = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      regRdData  <= 16'h0000;
      regRdValid <= 1'b0;
      regAddrErr <= 1'b0;
    end
    else
    begin
      regRdData  <= regReq.rd ? rdMux : 16'h0000;
      regRdValid <= regReq.rd;
      regAddrErr <= (regReq.rd || regReq.wr) && rdMiss;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  bitrate_apply_a: assert property (
    applyPulse && brSel_q <= `SCC_BR_MAX |=> bitrateCode == $past(brSel_q[1:0]))
    else $error("applied bitrate does not match select");
  bitrate_invalid_a: assert property (
    applyPulse && brSel_q > `SCC_BR_MAX |=> bitrateCode == `SCC_BR_OFF)
    else $error("invalid bitrate not reported as zero");
  count_range_a: assert property (
    outCfg_q <= `SCC_CNT_MAX && inCfg_q <= `SCC_CNT_MAX)
    else $error("module count beyond 32");
  mismatch_err_a: assert property (
    masterMode && state_q == scc_pkg::SCC_RUN && scanDone && mismatch ##1 masterMode
    |-> chainError ##0 modeStatus == `SCC_ERR_MODE)
    else $error("count mismatch did not raise error");
  auto_wins_a: assert property (
    applyPulse && masterMode && autoDetect |=> outModsUsed == $past(detOutCount)
    && inModsUsed == $past(detInCount))
    else $error("auto detection did not take precedence");
  slave_counts_a: assert property (
    applyPulse && !masterMode |=> outModsUsed == 6'h00 && inModsUsed == 6'h00)
    else $error("counts used outside master mode");
  used_read_a: assert property (
    regReq.rd && regReq.addr == `SCC_A_OUT_NOW
    |=> regRdValid && regRdData == {10'h000, $past(outModsUsed)})
    else $error("output modules read back wrong");
  type_read_a: assert property (
    regReq.rd && regReq.addr == `SCC_A_TYPE |=> regRdData == {8'h00, MODULE_TYPE})
    else $error("module type read back wrong");
  chain_safe_a: assert property (
    !chainInValid && policy_q[`SCC_POL_CH_HI:`SCC_POL_CH_LO] == `SCC_POL_ONE
    |=> chainOutSafe == {DATA_W{1'b1}})
    else $error("stale chain data not forced to ones");
  fb_safe_a: assert property (
    !fbValid && policy_q[`SCC_POL_FB_HI:`SCC_POL_FB_LO] == `SCC_POL_ZERO
    |=> fbOutSafe == '0)
    else $error("stale fieldbus data not forced to zeros");
  link_hold_a: assert property (
    !linkValid && policy_q[`SCC_POL_LK_HI:`SCC_POL_LK_LO] == `SCC_POL_HOLD
    |=> $stable(linkOutSafe))
    else $error("stale serial data not held");

  error_seen_c: cover property (state_q == scc_pkg::SCC_RUN ##1 chainError);
  timeout_c:    cover property (chainInValid ##1 !chainInValid);
  auto_used_c:  cover property (applyPulse && masterMode && autoDetect);
  recover_c:    cover property (chainError ##1 state_q == scc_pkg::SCC_RUN);
endmodule // scc_config_regs

// ### dv/scc_chain_model.sv
// Behavioural chain of external 8-bit shift register modules
`timescale 1ns/10ps
module scc_chain_model (
  input  wire logic       ref_clk,      // Clock
  output logic            scanDone,     // Scan finished pulse
  output logic      [5:0] detOutCount,  // Detected output modules
  output logic      [5:0] detInCount,   // Detected input modules
  output logic            chainProduce  // Input data produced
);
  initial
  begin
    scanDone     = 1'b0;
    chainProduce = 1'b0;
    detOutCount  = 6'h2A;
    detInCount   = 6'h15;
  end
  // --------------------------------------------------------------
  // Scan and production, entered at a falling edge
  // --------------------------------------------------------------
  // Counts are only meaningful in the scan cycle, so they are inverted after it
  task automatic scan(input logic [5:0] o, input logic [5:0] i);
    scanDone    = 1'b1;
    detOutCount = o;
    detInCount  = i;
    @(negedge ref_clk);
    scanDone    = 1'b0;
    detOutCount = ~o;
    detInCount  = ~i;
  endtask
  task automatic produce;
    chainProduce = 1'b1;
    @(negedge ref_clk);
    chainProduce = 1'b0;
  endtask
endmodule  // scc_chain_model

// ### dv/testbench.sv
// Self-checking bench for the shift-chain configuration bank
`timescale 1ns/10ps
`include "scc_defines.svh"
module testbench;
  localparam logic [7:0] TYPE_ID = 8'h5A;  // Arbitrary value
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  scc_pkg::scc_reg_req_t regReq = '0;
  logic [15:0] regRdData;
  logic        regRdValid, regAddrErr, lastErr, chainError, portEnable, chainInValid;
  logic        masterMode = 1'b1, autoDetect = 1'b0, applyPulse = 1'b0;
  logic        fbValid = 1'b1, linkValid = 1'b1, scanDone, chainProduce;
  logic [2:0]  currentMode = 3'h2, modeStatus;
  logic [5:0]  detOutCount, detInCount, outModsUsed, inModsUsed;
  logic [1:0]  bitrateCode;
  logic [15:0] chainOutRaw = '0, fbOutRaw = '0, linkOutRaw = '0;
  logic [15:0] chainOutSafe, fbOutSafe, linkOutSafe;
  int          n_fail = 0, tests_run = 0;
  always #2 ref_clk = ~ref_clk;
  scc_config_regs #(.DATA_W(16), .MS_CYCLES(4), .MODULE_TYPE(TYPE_ID)) dut (
    .ref_clk(ref_clk), .rst(rst), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid), .regAddrErr(regAddrErr), .masterMode(masterMode),
    .autoDetect(autoDetect), .currentMode(currentMode), .modeStatus(modeStatus),
    .scanDone(scanDone), .detOutCount(detOutCount), .detInCount(detInCount),
    .applyPulse(applyPulse), .chainError(chainError), .bitrateCode(bitrateCode),
    .portEnable(portEnable), .outModsUsed(outModsUsed), .inModsUsed(inModsUsed),
    .chainProduce(chainProduce), .chainInValid(chainInValid),
    .chainOutRaw(chainOutRaw), .chainOutSafe(chainOutSafe), .fbValid(fbValid),
    .fbOutRaw(fbOutRaw), .fbOutSafe(fbOutSafe), .linkValid(linkValid),
    .linkOutRaw(linkOutRaw), .linkOutSafe(linkOutSafe));
  scc_chain_model model (.ref_clk(ref_clk), .scanDone(scanDone),
    .detOutCount(detOutCount), .detInCount(detInCount), .chainProduce(chainProduce));
  // --------------------------------------------------------------
  // Shared tasks, all entered and left at a falling edge
  // --------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    regReq = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge ref_clk);
    regReq = '0;
    // Idle cycle keeps back-to-back requests apart
    @(negedge ref_clk);
  endtask
  task automatic rd(input string n, input logic [15:0] a, input logic [15:0] e);
    regReq = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
    @(negedge ref_clk);
    chk("rdValid", 32'h1, {31'h0, regRdValid});
    chk(n, {16'h0, e}, {16'h0, regRdData});
    lastErr = regAddrErr;
    regReq  = '0;
    @(negedge ref_clk);
  endtask
  task automatic apply;
    applyPulse = 1'b1;
    @(negedge ref_clk);
    applyPulse = 1'b0;
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    chk("bitrateCode", 32'h0, {30'h0, bitrateCode});
    rd("brSel", `SCC_A_BR_SEL, 16'h0001);
    rd("outCfg", `SCC_A_OUT_CFG, 16'h0000);
    rd("inCfg", `SCC_A_IN_CFG, 16'h0000);
    rd("policy", `SCC_A_POLICY, 16'h0000);
    rd("validity", `SCC_A_VALID, 16'h0000);
    wr(`SCC_A_TYPE, 16'h00FF);
    rd("typeId", `SCC_A_TYPE, {8'h00, TYPE_ID});
    rd("unmapped", 16'h0030, 16'h0000);
    chk("addrErr", 32'h1, {31'h0, lastErr});
  endtask
  task automatic t_bitrate;
    logic [7:0] code;
    logic [1:0] exp;
    for (int c = 0; c < 5; c++)
    begin
      code = (c == 4) ? 8'h07 : 8'(c);
      exp  = (c == 4) ? 2'h0 : 2'(c);
      wr(`SCC_A_BR_SEL, {8'h00, code});
      rd("brSel", `SCC_A_BR_SEL, {8'h00, code});
      apply();
      chk("bitrateCode", {30'h0, exp}, {30'h0, bitrateCode});
      chk("portEnable", {31'h0, exp != 2'h0}, {31'h0, portEnable});
      rd("brNow", `SCC_A_BR_NOW, {14'h0, exp});
    end
  endtask
  task automatic t_counts;
    wr(`SCC_A_OUT_CFG, 16'h0020);
    wr(`SCC_A_OUT_CFG, 16'h0021);
    wr(`SCC_A_IN_CFG, 16'h0007);
    rd("outCfg", `SCC_A_OUT_CFG, 16'h0020);
    apply();
    chk("outUsed", 32'h20, {26'h0, outModsUsed});
    chk("inUsed", 32'h07, {26'h0, inModsUsed});
    rd("outNow", `SCC_A_OUT_NOW, 16'h0020);
    rd("inNow", `SCC_A_IN_NOW, 16'h0007);
    autoDetect = 1'b1;
    applyPulse = 1'b1;
    model.scan(6'h05, 6'h09);
    applyPulse = 1'b0;
    chk("autoOut", 32'h05, {26'h0, outModsUsed});
    chk("autoIn", 32'h09, {26'h0, inModsUsed});
    chk("autoErr", 32'h0, {31'h0, chainError});
    autoDetect = 1'b0;
    masterMode = 1'b0;
    apply();
    chk("slaveOut", 32'h0, {26'h0, outModsUsed});
    chk("slaveIn", 32'h0, {26'h0, inModsUsed});
    masterMode = 1'b1;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic t_error;
    model.scan(6'h20, 6'h06);
    chk("chainError", 32'h1, {31'h0, chainError});
    chk("modeStatus", 32'h4, {29'h0, modeStatus});
    @(negedge ref_clk);
    model.scan(6'h20, 6'h07);
    chk("chainError", 32'h0, {31'h0, chainError});
    chk("modeStatus", 32'h2, {29'h0, modeStatus});
  endtask
  task automatic t_validity;
    logic [15:0] exp;
    for (int c = 0; c < 4; c++)
    begin
      wr(`SCC_A_POLICY, {10'h000, 2'(c), 2'(c), 2'(c)});
      wr(`SCC_A_VALID, 16'h0002);
      {chainOutRaw, fbOutRaw, linkOutRaw} = {3{16'hA5C3}};
      fbValid = 1'b1;
      linkValid = 1'b1;
      model.produce();
      @(negedge ref_clk);
      chk("inValid", 32'h1, {31'h0, chainInValid});
      chk("chainSafe", 32'hA5C3, {16'h0, chainOutSafe});
      repeat (12) @(negedge ref_clk);
      chk("inValid", 32'h0, {31'h0, chainInValid});
      fbValid = 1'b0;
      linkValid = 1'b0;
      {chainOutRaw, fbOutRaw, linkOutRaw} = {3{16'h3C5A}};
      repeat (2) @(negedge ref_clk);
      // Unused code 11 falls back to zeros
      exp = (c == 1) ? 16'hFFFF : (c == 2) ? 16'hA5C3 : 16'h0000;
      chk("chainSafe", {16'h0, exp}, {16'h0, chainOutSafe});
      chk("fbSafe", {16'h0, exp}, {16'h0, fbOutSafe});
      chk("linkSafe", {16'h0, exp}, {16'h0, linkOutSafe});
    end
    wr(`SCC_A_VALID, 16'h0000);
    chk("inValidZero", 32'h1, {31'h0, chainInValid});
    model.produce();
    repeat (20) @(negedge ref_clk);
    chk("inValid", 32'h1, {31'h0, chainInValid});
  endtask
  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    t_bitrate();
    t_counts();
    t_error();
    t_validity();
    report_and_stop();
  end
  // Whole run is under two hundred cycles, so this margin only trips on a hang
  initial
  begin
    #(5000 * 4);
    n_fail++;
    report_and_stop();
  end
endmodule  // testbench
